//--- dv/dac_ctl_props.sv
// Purpose: Link wire checks between host and device.
// Assumes: One clock domain, i_clk_sys.
// Notes:   Takes the interface signals as plain inputs.
`timescale 1ns/10ps
module dac_ctl_props (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Link wires.
  input wire logic ctl_serial_clock,
  input wire logic ctl_port_select,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic ctl_serial_data_in
);
  // ==========
  // Clock pulse count
  logic       clk_q;
  logic [4:0] pulses;
  // Deselect clears the count.
  always_ff @(posedge i_clk_sys)
  begin
    clk_q <= ctl_serial_clock;
    if (i_srst || ctl_port_select)
      pulses <= 5'h00;
    else if (ctl_serial_clock && !clk_q)
      pulses <= pulses + 5'h01;
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  // ==========
  // Assertions
  a_word_pulses: assert property (
    $rose(ctl_port_select) |-> pulses == 5'h10) else $error("pulses");
  a_write_bit: assert property (
    $fell(ctl_port_select) |-> !ctl_serial_data_in) else $error("wbit");
  a_sel_clk_low: assert property (
    $fell(ctl_port_select) |-> !ctl_serial_clock) else $error("sel");
  a_clk_half: assert property (
    $rose(ctl_serial_clock) |-> ctl_serial_clock[*8]) else $error("clk");
  a_dev_drain: assert property (
    sda_dev_oe |-> !sda_dev_o) else $error("dev high");
  a_host_drain: assert property (
    sda_host_oe |-> !sda_host_o) else $error("host high");
  a_dev_clk_low: assert property (
    $changed(sda_dev_oe) |-> !ctl_serial_clock) else $error("dev edge");
  a_ack_stands: assert property (
    $rose(sda_dev_oe) |=> sda_dev_oe[*8]) else $error("ack short");
  // Main scenarios reached.
  c_word_end: cover property ($rose(ctl_port_select));
  c_ack: cover property ($rose(sda_dev_oe));
  c_start: cover property (ctl_serial_clock && $fell(ctl_serial_data_in));
endmodule : dac_ctl_props

//--- dv/testbench.sv
// Purpose: Self-checking bench for control host and device.
// Assumes: Both ends run on one 25 MHz clock.
// Notes:   The device is rebooted by its reset pin for each mode.
`timescale 1ns/10ps
module testbench;
  import dac_ctl_pkg::*;
  // ==========
  // Signals
  logic        clk, srst, rst_n, lvl, open_s, valid, done, ack;
  logic        int_rst, wr_stb, sel, a1;
  logic [3:0]  pidx;
  logic [1:0]  dev, mode;
  logic [6:0]  addr, wr_addr;
  logic [7:0]  wdat, rd, peek, wr_data;
  logic [9:0]  nd;
  logic [31:0] seed = 32'h3;
  logic [31:0] v;
  cmd_t        kind;
  int          i, tests_run = 0, fail_count = 0;
  logic [15:0] q_wr[$];
  logic [9:0]  q_done[$];
  dac_ctl_if i_dac_ctl_if ();
  dac_ctl_host i_dac_ctl_host (.i_clk_sys(clk), .i_srst(srst),
    .i_ce(1'b1), .i_cmd_valid(valid), .o_cmd_ready(), .i_cmd_kind(kind),
    .i_cmd_dev(dev), .i_cmd_addr(addr), .i_cmd_data(wdat),
    .i_sel_idle(sel), .o_done(done), .o_ack_ok(ack), .o_rd_data(rd),
    .link(i_dac_ctl_if.host));
  dac_ctl_device i_dac_ctl_device (.i_clk_sys(clk), .i_srst(srst),
    .i_ce(1'b1), .i_rst_pin_n(rst_n), .i_mode_level(lvl),
    .i_mode_open(open_s), .i_addr_bit1(a1), .i_peek_idx(pidx),
    .o_peek_data(peek), .o_int_rst(int_rst), .o_mode(mode),
    .o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .link(i_dac_ctl_if.device));
  dac_ctl_props i_dac_ctl_props (.i_clk_sys(clk), .i_srst(srst),
    .ctl_serial_clock(i_dac_ctl_if.ctl_serial_clock),
    .ctl_port_select(i_dac_ctl_if.ctl_port_select),
    .sda_host_o(i_dac_ctl_if.sda_host_o),
    .sda_host_oe(i_dac_ctl_if.sda_host_oe),
    .sda_dev_o(i_dac_ctl_if.sda_dev_o),
    .sda_dev_oe(i_dac_ctl_if.sda_dev_oe),
    .ctl_serial_data_in(i_dac_ctl_if.ctl_serial_data_in));
  // ==========
  // Tasks
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h not %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test(input logic hung);
    if (hung)
      fail_count++;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Issues one command and waits for its end.
  task automatic cmd(input cmd_t k, input logic [1:0] d,
                     input logic [6:0] a, input logic [7:0] w);
    int n;
    valid <= 1'b1;
    kind  <= k;
    dev   <= d;
    addr  <= a;
    wdat  <= w;
    @(posedge clk);
    valid <= 1'b0;
    for (n = 0; n < 5000 && done !== 1'b1; n++)
      @(negedge clk);
    if (n == 5000)
      stop_test(1'b1);
    @(posedge clk);
  endtask : cmd
  // Pulses the reset pin with new straps.
  task automatic reboot(input logic lv, input logic op, input logic [1:0] m);
    int n;
    rst_n  <= 1'b0;
    lvl    <= lv;
    open_s <= op;
    repeat (8) @(negedge clk);
    check({15'h0, int_rst}, 16'h1);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    lvl <= !lv;
    for (n = 0; n < 5000 && int_rst !== 1'b0; n++)
      @(negedge clk);
    if (n == 5000)
      stop_test(1'b1);
    check({15'h0, n >= 3826 && n <= 3846}, 16'h1);
    check({14'h0, mode}, {14'h0, m});
    @(posedge clk);
  endtask : reboot
  // ==========
  // Clock, and the monitor of results.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk)
  begin
    if (wr_stb === 1'b1)
      check({1'b0, wr_addr, wr_data}, q_wr.pop_front());
    if (done === 1'b1)
    begin
      nd = q_done.pop_front();
      check({7'h0, ack, nd[9] ? rd : 8'h0}, {7'h0, nd[8:0]});
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    {srst, rst_n, lvl, open_s, valid, sel, a1, pidx} = 11'h6BF;
    {dev, addr, wdat, kind} = '0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    reboot(1'b1, 1'b0, MODE_SPI);
    for (i = 0; i < 4; i++)
    begin
      v = xs();
      q_wr.push_back({1'b0, REG_FIRST + 7'(i * 5), v[7:0]});
      q_done.push_back(10'h100);
      cmd(CMD_SPI_WR, 2'h3, REG_FIRST + 7'(i * 5), v[7:0]);
    end
    q_done.push_back(10'h100);
    cmd(CMD_SPI_WR, 2'h3, 7'h20, 8'hA5);
    repeat (10) @(negedge clk);
    check({8'h0, peek}, {8'h0, v[7:0]});
    $display("three-wire test ended");
    reboot(1'b0, 1'b0, MODE_I2C);
    check({8'h0, peek}, 16'h0);
    q_done.push_back(10'h300);
    cmd(CMD_I2C_RD, 2'h3, 7'h4F, 8'h0);
    v = xs();
    q_wr.push_back({9'h04F, v[7:0]});
    q_done.push_back(10'h100);
    cmd(CMD_I2C_WR, 2'h3, 7'h4F, v[7:0]);
    q_done.push_back({2'h3, v[7:0]});
    cmd(CMD_I2C_RD, 2'h3, 7'h4F, 8'h0);
    q_done.push_back(10'h000);
    cmd(CMD_I2C_WR, 2'h1, 7'h41, 8'h11);
    q_done.push_back(10'h000);
    cmd(CMD_I2C_WR, 2'h3, 7'h50, 8'h22);
    $display("two-wire test ended");
    reboot(1'b0, 1'b1, MODE_PAR);
    $display("parallel test ended");
    stop_test(1'b0);
  end
endmodule : testbench

//--- verilog/dac_ctl_device.sv
// Purpose: Control port of an eight-channel audio DAC.
// Assumes: Link pins are asynchronous and slower than i_clk_sys / 8.
// Notes:   Three-wire write port or two-wire slave, chosen by strap.
//
// Summary of operation
// RULE1: Control port runs apart from audio clocks.
// RULE2: Word starts write zero, then seven address bits.
// RULE3: Last eight word bits are register data.
// RULE4: Host: select low, then sixteen clock pulses.
// RULE5: Data commits when select rises after word.
// RULE6: Further bytes go to successive registers.
// RULE7: Select high ends a multiple write.
// RULE8: Two-wire mode: fast slave, receive and transmit.
// RULE9: Slave address upper five bits are 10011.
// RULE10: Two low address bits follow select pins.
// RULE11: Low acknowledge accepts, high means not accepted.
// RULE12: Host write: start, address, index, data, stop.
// RULE13: Index increments after each data byte.
// RULE14: Index wraps from last to first register.
// RULE15: Undefined register access gets no acknowledge.
// RULE16: Bytes are eight bits, most significant first.
// RULE17: Read returns byte selected by written index.
// RULE18: Host read: repeated start, same address, NACK.
// RULE19: Reset pin low clears registers, powers down.
// RULE20: Internal reset released 3846 cycles after release.
// RULE21: Mode strap sampled only at reset release.
// RULE22: Strap low two-wire, high three-wire, open parallel.
// RULE23: Data sampled on rising clock while selected.
`timescale 1ns/10ps
module dac_ctl_device (
  // Clock, reset and enable.
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  input  wire logic       i_ce,
  // Reset pin and straps.
  input  wire logic       i_rst_pin_n,
  input  wire logic       i_mode_level,
  input  wire logic       i_mode_open,
  input  wire logic       i_addr_bit1,
  // Register read-back.
  input  wire logic [3:0] i_peek_idx,
  output logic      [7:0] o_peek_data,
  // Status and register write strobe.
  output logic            o_int_rst,
  output logic      [1:0] o_mode,
  output logic            o_wr_stb,
  output logic      [6:0] o_wr_addr,
  output logic      [7:0] o_wr_data,
  // Link pins.
  dac_ctl_if.device       link
);
  import dac_ctl_pkg::*;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_DEV  = 8'h02,
    S_REG  = 8'h04,
    S_WR   = 8'h08,
    S_RD   = 8'h10,
    S_SACK = 8'h20,
    S_MACK = 8'h40,
    S_WAIT = 8'h80
  } i2c_state_t;

  localparam logic [11:0] RST_CNT_END = 12'(RST_RELEASE_CYCLES);
  localparam logic [11:0] MODE_END    = 12'(MODE_SETTLE_CYCLES);

  logic [6:0]  lv;
  logic        scl_s;
  logic        sda_s;
  logic        sel_s;
  logic        a1_s;
  logic        rst_s;
  logic        scl_d;
  logic        sda_d;
  logic        sel_d;
  logic        scl_rise;
  logic        scl_fall;
  logic        sel_rise;
  logic        start_ev;
  logic        stop_ev;
  logic [11:0] rst_cnt;
  logic [7:0]  regs [REG_COUNT];
  logic [4:0]  spi_cnt;
  logic [7:0]  spi_rx;
  logic [7:0]  spi_sh;
  logic [6:0]  spi_addr;
  logic [7:0]  spi_data;
  logic        spi_ok;
  logic        spi_pend;
  logic        spi_wr;
  logic [6:0]  spi_wa;
  logic [7:0]  spi_wd;
  i2c_state_t  st;
  i2c_state_t  ret;
  logic [3:0]  bcnt;
  logic [7:0]  sh;
  logic [7:0]  tx;
  logic [6:0]  idx;
  logic        pull;
  logic        rx_done;
  logic        i2c_wr;
  logic [6:0]  i2c_wa;
  logic [7:0]  i2c_wd;

  // ==========================================================
  // Pin synchronisers
  // Every pin is sampled by the system clock only.
  dac_ctl_sync3 #(.W(7)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_raw     ({link.ctl_serial_clock, link.ctl_serial_data_in,
                 link.ctl_port_select, i_addr_bit1, i_rst_pin_n,
                 i_mode_level, i_mode_open}), // RULE1
    .o_level   (lv)
  );

  // Filtered pin levels and their edges.
  assign {scl_s, sda_s, sel_s, a1_s, rst_s} = lv[6:2];
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign sel_rise = sel_s && !sel_d;
  assign start_ev = scl_s && scl_d && !sda_s && sda_d;
  assign stop_ev  = scl_s && scl_d && sda_s && !sda_d;

  // Previous levels for edge finding.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      sel_d <= 1'b1;
    end
    else if (i_ce)
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      sel_d <= sel_s;
    end
  end

  // ==========================================================
  // Internal reset and mode strap
  // Reset pin low holds reset; release waits the full count.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      rst_cnt   <= '0;
      o_int_rst <= 1'b1;
    end
    else if (i_ce)
    begin
      if (!rst_s)
      begin
        rst_cnt   <= '0; // RULE19
        o_int_rst <= 1'b1; // RULE19
      end
      else if (rst_cnt == RST_CNT_END)
        o_int_rst <= 1'b0; // RULE20
      else
        rst_cnt <= rst_cnt + 12'h001; // RULE20
    end
  end

  // The strap is taken while the reset pin is low and for eight cycles after its release.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      o_mode <= MODE_PAR;
    else if (i_ce && o_int_rst && rst_cnt < MODE_END) // RULE21
    begin
      if (lv[0])
        o_mode <= MODE_PAR; // RULE22
      else if (lv[1])
        o_mode <= MODE_SPI; // RULE22
      else
        o_mode <= MODE_I2C; // RULE22
    end
  end

  // ==========================================================
  // Register file
  // Each entry clears on reset and takes its own write.
  for (genvar g = 0; g < REG_COUNT; g++)
  begin : g_reg
    always_ff @(posedge i_clk_sys)
    begin
      if (i_srst || o_int_rst)
        regs[g] <= REG_DEFAULT; // RULE19
      else if (i_ce && o_wr_stb && o_wr_addr[3:0] == 4'(g))
        regs[g] <= o_wr_data;
    end
  end

  // Write strobe merges both engines; only one runs per mode.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_wr_stb    <= 1'b0;
      o_wr_addr   <= '0;
      o_wr_data   <= '0;
      o_peek_data <= '0;
    end
    else if (i_ce)
    begin
      o_wr_stb    <= spi_wr || i2c_wr;
      o_wr_addr   <= spi_wr ? spi_wa : i2c_wa;
      o_wr_data   <= spi_wr ? spi_wd : i2c_wd;
      o_peek_data <= regs[i_peek_idx];
    end
  end

  // ==========================================================
  // Three-wire write engine
  assign spi_rx = {spi_sh[6:0], sda_s}; // RULE2

  // A byte waits as pending until select rises or a next byte ends.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      spi_cnt  <= '0;
      spi_sh   <= '0;
      spi_addr <= '0;
      spi_data <= '0;
      spi_ok   <= 1'b0;
      spi_pend <= 1'b0;
      spi_wr   <= 1'b0;
      spi_wa   <= '0;
      spi_wd   <= '0;
    end
    else if (i_ce)
    begin
      spi_wr <= 1'b0;
      if (o_mode != MODE_SPI || sel_rise)
      begin
        spi_wr   <= spi_pend && spi_ok; // RULE5 RULE7
        spi_wa   <= spi_addr;
        spi_wd   <= spi_data;
        spi_pend <= 1'b0;
        spi_cnt  <= '0;
      end
      else if (!sel_s && scl_rise) // RULE23
      begin
        spi_sh <= spi_rx;
        if (spi_cnt == SPI_ADR_END)
        begin
          spi_ok   <= !spi_rx[7] && reg_defined(spi_rx[6:0]); // RULE2
          spi_addr <= spi_rx[6:0]; // RULE2
        end
        if (spi_cnt == SPI_WRD_END)
        begin
          spi_cnt  <= SPI_ADR_END + 5'h01; // RULE6
          spi_pend <= 1'b1;
          spi_data <= spi_rx; // RULE3
          if (spi_pend)
          begin
            spi_wr   <= spi_ok; // RULE6
            spi_wa   <= spi_addr;
            spi_wd   <= spi_data;
            spi_addr <= next_index(spi_addr); // RULE6
          end
        end
        else
          spi_cnt <= spi_cnt + 5'h01;
      end
    end
  end

  // ==========================================================
  // Two-wire slave engine
  assign rx_done        = scl_fall && bcnt == BYTE_BITS;
  assign link.sda_dev_o  = 1'b0;
  assign link.sda_dev_oe = pull; // RULE11

  // Byte framing, acknowledge and read transmission.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      st     <= S_IDLE;
      ret    <= S_IDLE;
      bcnt   <= '0;
      sh     <= '0;
      tx     <= '0;
      idx    <= REG_FIRST;
      pull   <= 1'b0;
      i2c_wr <= 1'b0;
      i2c_wa <= '0;
      i2c_wd <= '0;
    end
    else if (i_ce)
    begin
      i2c_wr <= 1'b0;
      if (o_mode != MODE_I2C || stop_ev)
      begin
        st   <= S_IDLE;
        pull <= 1'b0;
      end
      else if (start_ev) // RULE8
      begin
        st   <= S_DEV;
        bcnt <= '0;
        pull <= 1'b0;
      end
      else
      begin
        if ((st == S_DEV || st == S_REG || st == S_WR) && scl_rise)
        begin
          sh   <= {sh[6:0], sda_s}; // RULE16
          bcnt <= bcnt + 4'h1;
        end
        case (st)
          S_DEV:
            if (rx_done)
            begin
              bcnt <= '0;
              st   <= S_SACK;
              if (sh[7:1] == {SLV_ADDR_HI, a1_s, sel_s}) // RULE9 RULE10
              begin
                pull <= 1'b1;
                ret  <= sh[0] ? S_RD : S_REG; // RULE17
              end
              else
                ret <= S_WAIT;
            end
          S_REG:
            if (rx_done)
            begin
              bcnt <= '0;
              st   <= S_SACK;
              if (!sh[7] && reg_defined(sh[6:0]))
              begin
                pull <= 1'b1;
                idx  <= sh[6:0]; // RULE17
                ret  <= S_WR;
              end
              else
                ret <= S_WAIT; // RULE15
            end
          S_WR:
            if (rx_done)
            begin
              bcnt   <= '0;
              st     <= S_SACK;
              pull   <= 1'b1;
              ret    <= S_WR;
              i2c_wr <= 1'b1;
              i2c_wa <= idx;
              i2c_wd <= sh;
              idx    <= next_index(idx); // RULE13 RULE14
            end
          S_SACK:
            if (scl_fall)
            begin
              st   <= ret;
              tx   <= {regs[idx[3:0]][6:0], 1'b1};
              pull <= (ret == S_RD) && !regs[idx[3:0]][7]; // RULE17
            end
          S_RD:
            if (scl_fall)
            begin
              if (bcnt == BYTE_BITS - 4'h1)
              begin
                bcnt <= '0;
                pull <= 1'b0;
                st   <= S_MACK;
              end
              else
              begin
                bcnt <= bcnt + 4'h1;
                pull <= !tx[7]; // RULE16
                tx   <= {tx[6:0], 1'b1};
              end
            end
          S_MACK:
            if (scl_rise)
            begin
              if (sda_s)
                st <= S_WAIT; // RULE11
              else
                idx <= next_index(idx); // RULE14
            end
            else if (scl_fall)
            begin
              st   <= S_RD;
              tx   <= {regs[idx[3:0]][6:0], 1'b1};
              pull <= !regs[idx[3:0]][7];
            end
          default:
            pull <= 1'b0;
        endcase
      end
    end
  end
endmodule : dac_ctl_device

//--- verilog/dac_ctl_host.sv
// Purpose: Control host that drives the DAC control port pins.
// Assumes: One command at a time; one data byte per command.
// Notes:   Link clock is divided from i_clk_sys and driven out.
`timescale 1ns/10ps
module dac_ctl_host (
  // Clock, reset and enable.
  input  wire logic               i_clk_sys,
  input  wire logic               i_srst,
  input  wire logic               i_ce,
  // Command request.
  input  wire logic               i_cmd_valid,
  output logic                    o_cmd_ready,
  input  wire dac_ctl_pkg::cmd_t  i_cmd_kind,
  input  wire logic [1:0]         i_cmd_dev,
  input  wire logic [6:0]         i_cmd_addr,
  input  wire logic [7:0]         i_cmd_data,
  input  wire logic               i_sel_idle,
  // Command answer.
  output logic                    o_done,
  output logic                    o_ack_ok,
  output logic [7:0]              o_rd_data,
  // Link pins.
  dac_ctl_if.host                 link
);
  import dac_ctl_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_START = 5'h02,
    H_BIT   = 5'h04,
    H_STOP  = 5'h08,
    H_SPI   = 5'h10
  } host_state_t;

  localparam logic [7:0] HALF  = 8'(SCL_HALF_CYC);
  localparam logic [7:0] FULL  = 8'(2 * SCL_HALF_CYC);
  localparam logic [7:0] TRIPL = 8'(3 * SCL_HALF_CYC);

  host_state_t st;
  cmd_t        kind;
  logic [7:0]  tk;
  logic [3:0]  bitn;
  logic [1:0]  byten;
  logic [1:0]  dev;
  logic [6:0]  addr;
  logic [7:0]  data;
  logic [7:0]  tx;
  logic [15:0] spiw;
  logic        sda_bit;

  // Byte sent in each position of a two-wire frame.
  function automatic logic [7:0] frame_byte(input logic [1:0] n);
    if (n == 2'h0)
      return {SLV_ADDR_HI, dev, 1'b0};
    else if (n == 2'h1)
      return {1'b0, addr};
    else if (n == 2'h2 && kind == CMD_I2C_WR)
      return data;
    else if (n == 2'h2)
      return {SLV_ADDR_HI, dev, 1'b1}; // RULE18
    else
      return 8'hFF;
  endfunction : frame_byte

  // ==========================================================
  // Pin drive
  assign o_cmd_ready      = (st == H_IDLE);
  assign link.sda_host_o  = 1'b0;
  assign link.sda_host_oe = !sda_bit;

  // ==========================================================
  // Sequencer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      st                    <= H_IDLE;
      kind                  <= CMD_SPI_WR;
      tk                    <= '0;
      bitn                  <= '0;
      byten                 <= '0;
      dev                   <= '0;
      addr                  <= '0;
      data                  <= '0;
      tx                    <= '0;
      spiw                  <= '0;
      sda_bit               <= 1'b1;
      link.ctl_serial_clock <= 1'b1;
      link.ctl_port_select  <= 1'b1;
      o_done                <= 1'b0;
      o_ack_ok              <= 1'b0;
      o_rd_data             <= '0;
    end
    else if (i_ce)
    begin
      o_done <= 1'b0;
      tk     <= tk + 8'h01;
      case (st)
        H_IDLE:
        begin
          tk                   <= '0;
          bitn                 <= '0;
          byten                <= '0;
          link.ctl_port_select <= i_sel_idle;
          if (i_cmd_valid)
          begin
            kind     <= i_cmd_kind;
            dev      <= i_cmd_dev;
            addr     <= i_cmd_addr;
            data     <= i_cmd_data;
            spiw     <= {1'b0, i_cmd_addr, i_cmd_data}; // RULE2 RULE3
            o_ack_ok <= 1'b1;
            st       <= (i_cmd_kind == CMD_SPI_WR) ? H_SPI : H_START;
          end
        end
        H_START:
        begin
          if (tk == 8'h00)
          begin
            link.ctl_serial_clock <= 1'b0;
            sda_bit               <= 1'b1;
          end
          if (tk == HALF)
            link.ctl_serial_clock <= 1'b1;
          if (tk == FULL)
            sda_bit <= 1'b0; // RULE12
          if (tk == TRIPL)
          begin
            link.ctl_serial_clock <= 1'b0;
            tx                    <= frame_byte(byten);
            bitn                  <= '0;
            tk                    <= '0;
            st                    <= H_BIT;
          end
        end
        H_BIT, H_SPI:
        begin
          if (tk == 8'h00)
          begin
            link.ctl_serial_clock <= 1'b0;
            if (st == H_SPI)
            begin
              link.ctl_port_select <= 1'b0; // RULE4
              sda_bit              <= spiw[15];
            end
            else
              sda_bit <= (bitn < BYTE_BITS) ? tx[7] : 1'b1; // RULE16
          end
          if (tk == HALF)
            link.ctl_serial_clock <= 1'b1;
          if (tk == FULL - 8'h01)
          begin
            tk   <= '0;
            bitn <= bitn + 4'h1;
            spiw <= {spiw[14:0], 1'b0};
            tx   <= {tx[6:0], 1'b1};
            if (st == H_SPI && bitn == 4'hF)
            begin
              link.ctl_port_select <= 1'b1; // RULE4 RULE5
              o_done               <= 1'b1;
              st                   <= H_IDLE;
            end
            else if (st == H_BIT && bitn < BYTE_BITS)
              o_rd_data <= {o_rd_data[6:0], link.ctl_serial_data_in};
            else if (st == H_BIT)
            begin
              bitn  <= '0;
              byten <= byten + 2'h1;
              tx    <= frame_byte(byten + 2'h1);
              if (byten != 2'h3 && link.ctl_serial_data_in)
              begin
                o_ack_ok <= 1'b0; // RULE11
                st       <= H_STOP;
              end
              else if (byten == 2'h3 ||
                       (kind == CMD_I2C_WR && byten == 2'h2))
                st <= H_STOP; // RULE12 RULE18
              else if (kind == CMD_I2C_RD && byten == 2'h1)
                st <= H_START; // RULE17 RULE18
            end
          end
        end
        H_STOP:
        begin
          if (tk == 8'h00)
            link.ctl_serial_clock <= 1'b0;
          if (tk == 8'h01)
            sda_bit <= 1'b0;
          if (tk == HALF)
            link.ctl_serial_clock <= 1'b1;
          if (tk == FULL)
            sda_bit <= 1'b1;
          if (tk == TRIPL)
          begin
            o_done <= 1'b1;
            st     <= H_IDLE;
          end
        end
        default:
          st <= H_IDLE;
      endcase
    end
  end
endmodule : dac_ctl_host

//--- verilog/dac_ctl_if.sv
// Purpose: Pins between the control host and the DAC control port.
// Assumes: Data line is open drain; clock and select are host driven.
// Notes:   The data line level is resolved here from both enables.
`timescale 1ns/10ps
interface dac_ctl_if;
  logic ctl_serial_clock;
  logic ctl_port_select;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic ctl_serial_data_in;

  // Any enabled driver that drives low pulls the line low.
  assign ctl_serial_data_in = !((sda_host_oe && !sda_host_o) ||
                                (sda_dev_oe && !sda_dev_o));

  modport host (output ctl_serial_clock, ctl_port_select, sda_host_o,
                sda_host_oe, input ctl_serial_data_in);
  modport device (input ctl_serial_clock, ctl_port_select,
                  ctl_serial_data_in, output sda_dev_o, sda_dev_oe);
endinterface : dac_ctl_if

//--- verilog/dac_ctl_pkg.sv
// Purpose: Shared constants and types of the DAC control port.
// Assumes: System clock of 25 MHz on both ends.
// Notes:   Register window is sixteen bytes with index wrap.
package dac_ctl_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ            = 25;
  localparam int RST_RELEASE_CYCLES = 3846;
  localparam int MODE_SETTLE_CYCLES = 8;
  // Least half period of the host link clock.
  localparam int SCL_HALF_NS        = 1250;
  localparam int SCL_HALF_CYC       = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Register window and addressing
  localparam logic [6:0] REG_FIRST   = 7'h40;
  localparam logic [6:0] REG_LAST    = 7'h4F;
  localparam int         REG_COUNT   = 16;
  localparam logic [7:0] REG_DEFAULT = 8'h00;
  localparam logic [4:0] SLV_ADDR_HI = 5'h13;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [4:0] SPI_ADR_END = 5'h07;
  localparam logic [4:0] SPI_WRD_END = 5'h0F;

  // ==========================================================
  // Modes and host commands
  localparam logic [1:0] MODE_I2C = 2'h0;
  localparam logic [1:0] MODE_SPI = 2'h1;
  localparam logic [1:0] MODE_PAR = 2'h2;

  typedef enum logic [1:0] {
    CMD_SPI_WR = 2'h0,
    CMD_I2C_WR = 2'h1,
    CMD_I2C_RD = 2'h2
  } cmd_t;

  // True for an address inside the register window.
  function automatic logic reg_defined(input logic [6:0] a);
    return a[6:4] == REG_FIRST[6:4];
  endfunction : reg_defined

  // Next register index, wrapping from the last to the first.
  function automatic logic [6:0] next_index(input logic [6:0] a);
    return (a == REG_LAST) ? REG_FIRST : a + 7'h01;
  endfunction : next_index

endpackage : dac_ctl_pkg

//--- verilog/dac_ctl_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to i_clk_sys.
// Notes:   A change is taken once stages two and three agree.
`timescale 1ns/10ps
module dac_ctl_sync3 #(
  parameter int W = 1
) (
  // Clock, reset and enable.
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  input  wire logic         i_ce,
  // Raw and filtered levels.
  input  wire logic [W-1:0] i_raw,
  output logic      [W-1:0] o_level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================
  // One chain per bit
  for (genvar g = 0; g < W; g++)
  begin : g_bit
    // Stage one feeds only stage two.
    always_ff @(posedge i_clk_sys)
    begin
      if (i_srst)
      begin
        s1[g]      <= 1'b0;
        s2[g]      <= 1'b0;
        s3[g]      <= 1'b0;
        o_level[g] <= 1'b0;
      end
      else if (i_ce)
      begin
        s1[g] <= i_raw[g];
        s2[g] <= s1[g];
        s3[g] <= s2[g];
        if (s2[g] == s3[g])
          o_level[g] <= s3[g];
      end
    end
  end
endmodule : dac_ctl_sync3
